// *** design/fup_flash_unlock_and_protect.sv ***
// Flash unlock sequencer and sector protection with a Wishbone register port
//
// Functional notes
// R1 - Reset always leaves controller locked
// R2 - Software: page, 73H, 8CH, same page
// R3 - Page mismatch relocks; match activates page
// R4 - 95H erases active page if unprotected
// R5 - Unknown control value relocks controller
// R6 - Mass erase only from debug port
// R7 - Unlocked page accepts repeated byte writes
// R8 - Control write after programming relocks
// R9 - Both options zero block all user writes
// R10 - Write protect option one permits all
// R11 - Eight sectors, at least one page
// R12 - Protected sector refuses program and erase
// R13 - Sector protect clears on every reset
// R14 - 5EH selects sector protect at page address
// R15 - Writing one sets protection, zero ignored
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "fup_params.svh"

module fup_flash_unlock_and_protect #(
    parameter int PAGE_W = 8,
    parameter int ADDR_W = 16,
    parameter int PAGE_BYTES = 512
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic prog_req_i,
    input wire logic [ADDR_W-1:0] prog_addr_i,
    input wire logic [7:0] prog_data_i,
    output logic prog_ok_o,
    output logic prog_strobe_o,
    output logic [ADDR_W-1:0] prog_addr_o,
    output logic [7:0] prog_data_o,
    output logic erase_strobe_o,
    output logic [PAGE_W-1:0] erase_page_o,
    input wire logic dbg_mass_req_i,
    output logic mass_strobe_o
);
    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int PAGE_SH = $clog2(PAGE_BYTES);
    localparam int NUM_PAGES = 1 << (ADDR_W - PAGE_SH);
    localparam int SECT_PAGES = (NUM_PAGES >= 8) ? NUM_PAGES / 8 : 1;
    localparam int NUM_SECT = (NUM_PAGES >= 8) ? 8 : NUM_PAGES;
    localparam int SECT_SH = $clog2(SECT_PAGES);

    if (PAGE_W < 1 || PAGE_W > 8 || ADDR_W <= PAGE_SH || (ADDR_W - PAGE_SH) > PAGE_W
        || PAGE_BYTES != (1 << PAGE_SH))
    begin : g_geom_bad
        $error("fup: unsupported geometry");
    end

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    fup_pkg::fup_state_t state_r;
    logic ack_r;
    logic [PAGE_W-1:0] page_r;
    logic [PAGE_W-1:0] active_page_r;
    logic [7:0] sect_prot_r;
    logic sect_sel_r;
    logic [1:0] opt_r;
    logic [7:0] err_r;
    logic wr_go;
    logic rd_go;
    logic ctrl_wr;
    logic page_wr;
    logic [7:0] wdat;
    logic user_ok;
    logic [2:0] act_sect;
    logic [2:0] prog_sect;
    logic [PAGE_W-1:0] prog_page;

    // Writes land at the edge that carries the acknowledge
    assign wr_go = wb_cyc_i && wb_stb_i && ack_r && wb_we_i && wb_sel_i[0];
    assign rd_go = wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i;
    assign ctrl_wr = wr_go && wb_adr_i == `FUP_ADR_CTRL;
    assign page_wr = wr_go && wb_adr_i == `FUP_ADR_PAGE;
    assign wdat = wb_dat_i[7:0];
    assign wb_ack_o = ack_r;

    // Write protect option opens all; otherwise user code is shut out
    assign user_ok = opt_r[`FUP_OPT_WP_BIT]; // see R9 see R10

    // Sector of a page
    assign act_sect = 3'((active_page_r >> SECT_SH) % NUM_SECT); // see R11
    assign prog_page = PAGE_W'(prog_addr_i >> PAGE_SH);
    assign prog_sect = 3'((prog_page >> SECT_SH) % NUM_SECT); // see R11

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_r <= 1'b0;
        else
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0;
        else if (rd_go)
        begin
            case (wb_adr_i)
                `FUP_ADR_PAGE: wb_dat_o <= sect_sel_r ? {24'h0, sect_prot_r} : 32'(page_r);
                `FUP_ADR_OPT: wb_dat_o <= {30'h0, opt_r};
                `FUP_ADR_STAT: wb_dat_o <= {8'h0, 8'(active_page_r), err_r, 5'h0, 3'(state_r)};
                default: wb_dat_o <= 32'h0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Option bits
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            opt_r <= 2'h0;
        else if (wr_go && wb_adr_i == `FUP_ADR_OPT)
            opt_r <= wdat[1:0];
    end

    // ----------------------------------------------------------------
    // Sector protect and page select
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sect_sel_r <= 1'b0;
        else if (ctrl_wr)
            sect_sel_r <= wdat == `FUP_CMD_SECSEL; // see R14
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sect_prot_r <= `FUP_RST_SECT; // see R13
        else if (page_wr && sect_sel_r)
            sect_prot_r <= sect_prot_r | wdat; // see R12 see R15
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            page_r <= PAGE_W'(`FUP_RST_PAGE);
        else if (page_wr && !sect_sel_r)
            page_r <= wdat[PAGE_W-1:0];
    end

    // ----------------------------------------------------------------
    // Unlock sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= fup_pkg::FUP_LOCKED; // see R1
            active_page_r <= '0;
        end
        else if (ctrl_wr)
        begin
            case (state_r)
                fup_pkg::FUP_LOCKED, fup_pkg::FUP_KEY2_SEEN:
                    state_r <= (wdat == `FUP_KEY1) ? fup_pkg::FUP_KEY1_SEEN : fup_pkg::FUP_LOCKED; // see R5
                fup_pkg::FUP_KEY1_SEEN:
                    state_r <= (wdat == `FUP_KEY2) ? fup_pkg::FUP_KEY2_SEEN : fup_pkg::FUP_LOCKED; // see R5
                fup_pkg::FUP_UNLOCKED:
                    state_r <= fup_pkg::FUP_LOCKED; // see R4 see R5
                fup_pkg::FUP_PROGRAMMING:
                    state_r <= fup_pkg::FUP_LOCKED; // see R8
                default:
                    state_r <= fup_pkg::FUP_LOCKED;
            endcase
        end
        else if (page_wr && !sect_sel_r && state_r == fup_pkg::FUP_KEY2_SEEN)
        begin
            if (wdat[PAGE_W-1:0] == page_r) // see R3
            begin
                state_r <= fup_pkg::FUP_UNLOCKED;
                active_page_r <= page_r;
            end
            else
                state_r <= fup_pkg::FUP_LOCKED; // see R3
        end
        else if (prog_ok_o && state_r == fup_pkg::FUP_UNLOCKED)
            state_r <= fup_pkg::FUP_PROGRAMMING; // see R7
    end

    // ----------------------------------------------------------------
    // Program, erase and mass erase
    // ----------------------------------------------------------------
    assign prog_ok_o = prog_req_i && user_ok && prog_page == active_page_r
        && (state_r == fup_pkg::FUP_UNLOCKED || state_r == fup_pkg::FUP_PROGRAMMING)
        && !sect_prot_r[prog_sect]; // see R7 see R12

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prog_strobe_o <= 1'b0;
            prog_addr_o <= '0;
            prog_data_o <= 8'h0;
            erase_strobe_o <= 1'b0;
            erase_page_o <= '0;
            mass_strobe_o <= 1'b0;
            err_r <= 8'h0;
        end
        else
        begin
            prog_strobe_o <= prog_ok_o; // see R7
            if (prog_ok_o)
            begin
                prog_addr_o <= prog_addr_i;
                prog_data_o <= prog_data_i;
            end
            erase_strobe_o <= ctrl_wr && wdat == `FUP_CMD_ERASE && state_r == fup_pkg::FUP_UNLOCKED
                && user_ok && !sect_prot_r[act_sect]; // see R4 see R12
            erase_page_o <= active_page_r;
            mass_strobe_o <= dbg_mass_req_i && sect_prot_r == 8'h00; // see R6 see R12
            if (ctrl_wr && wdat == `FUP_CMD_MASS)
                err_r <= err_r + 8'h1; // see R6
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_reset_locked;
        @(posedge clk_i) rst_i |=> state_r == fup_pkg::FUP_LOCKED;
    endproperty
    a_reset_locked: assert property (p_reset_locked) else $error("not locked after reset"); // see R1

    sequence s_key1;
        ctrl_wr && wdat == `FUP_KEY1;
    endsequence
    sequence s_key2;
        ctrl_wr && wdat == `FUP_KEY2;
    endsequence
    property p_keys;
        @(posedge clk_i) disable iff (rst_i)
        state_r == fup_pkg::FUP_LOCKED ##0 s_key1 |=> state_r == fup_pkg::FUP_KEY1_SEEN;
    endproperty
    a_keys: assert property (p_keys) else $error("first key did not arm"); // see R2

    property p_key2;
        @(posedge clk_i) disable iff (rst_i)
        state_r == fup_pkg::FUP_KEY1_SEEN ##0 s_key2 |=> state_r == fup_pkg::FUP_KEY2_SEEN;
    endproperty
    a_key2: assert property (p_key2) else $error("second key did not arm"); // see R2

    property p_page_match;
        @(posedge clk_i) disable iff (rst_i)
        state_r == fup_pkg::FUP_KEY2_SEEN && page_wr && !sect_sel_r
        |=> (state_r == fup_pkg::FUP_UNLOCKED) == ($past(wdat[PAGE_W-1:0]) == $past(page_r));
    endproperty
    a_page_match: assert property (p_page_match) else $error("page compare wrong"); // see R3

    property p_bad_ctrl;
        @(posedge clk_i) disable iff (rst_i)
        ctrl_wr && wdat != `FUP_KEY1 && wdat != `FUP_KEY2 |=> state_r == fup_pkg::FUP_LOCKED;
    endproperty
    a_bad_ctrl: assert property (p_bad_ctrl) else $error("control write did not lock"); // see R5 see R8

    property p_erase_prot;
        @(posedge clk_i) disable iff (rst_i)
        erase_strobe_o |-> !sect_prot_r[act_sect] && $past(user_ok);
    endproperty
    a_erase_prot: assert property (p_erase_prot) else $error("erase of protected page"); // see R4 see R12

    property p_mass_dbg;
        @(posedge clk_i) disable iff (rst_i)
        mass_strobe_o |-> $past(dbg_mass_req_i);
    endproperty
    a_mass_dbg: assert property (p_mass_dbg) else $error("mass erase without debug"); // see R6

    property p_opts_block;
        @(posedge clk_i) disable iff (rst_i)
        !opt_r[`FUP_OPT_WP_BIT] |-> !prog_ok_o ##1 !erase_strobe_o;
    endproperty
    a_opts_block: assert property (p_opts_block) else $error("write with options closed"); // see R9

    property p_sticky;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (sect_prot_r & $past(sect_prot_r)) == $past(sect_prot_r);
    endproperty
    a_sticky: assert property (p_sticky) else $error("protection cleared"); // see R15 see R12

    property p_stay_open;
        @(posedge clk_i) disable iff (rst_i)
        prog_ok_o && !ctrl_wr |=> state_r == fup_pkg::FUP_PROGRAMMING;
    endproperty
    a_stay_open: assert property (p_stay_open) else $error("page relocked after byte"); // see R7

    property p_prot_reset;
        @(posedge clk_i)
        rst_i |=> sect_prot_r == 8'h00;
    endproperty
    a_prot_reset: assert property (p_prot_reset) else $error("protection kept over reset"); // see R13

    property p_sect_sel;
        @(posedge clk_i) disable iff (rst_i)
        ctrl_wr && wdat == `FUP_CMD_SECSEL |=> sect_sel_r;
    endproperty
    a_sect_sel: assert property (p_sect_sel) else $error("sector protect not selected"); // see R14

    property p_prog_strobe;
        @(posedge clk_i) disable iff (rst_i)
        prog_ok_o |=> prog_strobe_o && prog_addr_o == $past(prog_addr_i) && prog_data_o == $past(prog_data_i);
    endproperty
    a_prog_strobe: assert property (p_prog_strobe) else $error("byte not handed on"); // see R7

    property p_wp_open;
        @(posedge clk_i) disable iff (rst_i)
        opt_r[`FUP_OPT_WP_BIT] && prog_req_i && state_r == fup_pkg::FUP_PROGRAMMING
            && prog_page == active_page_r && !sect_prot_r[prog_sect] |-> prog_ok_o;
    endproperty
    a_wp_open: assert property (p_wp_open) else $error("open option refused byte"); // see R10

    property p_user_mass;
        @(posedge clk_i) disable iff (rst_i)
        ctrl_wr && wdat == `FUP_CMD_MASS && !dbg_mass_req_i |=> !mass_strobe_o;
    endproperty
    a_user_mass: assert property (p_user_mass) else $error("user mass erase accepted"); // see R6

    property p_erase_relock;
        @(posedge clk_i) disable iff (rst_i)
        erase_strobe_o |-> state_r == fup_pkg::FUP_LOCKED;
    endproperty
    a_erase_relock: assert property (p_erase_relock) else $error("not locked after erase"); // see R4

    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge longer than one cycle");
endmodule
`default_nettype wire

// *** design/fup_params.svh ***
// Offsets, fields, reset values and codes of the flash unlock and protect block
`ifndef FUP_PARAMS_SVH
`define FUP_PARAMS_SVH
`define FUP_ADR_CTRL 4'h0
`define FUP_ADR_PAGE 4'h4
`define FUP_ADR_OPT 4'h8
`define FUP_ADR_STAT 4'hc
`define FUP_KEY1 8'h73
`define FUP_KEY2 8'h8c
`define FUP_CMD_ERASE 8'h95
`define FUP_CMD_SECSEL 8'h5e
`define FUP_CMD_MASS 8'h63
`define FUP_OPT_WP_BIT 0
`define FUP_OPT_HS_BIT 1
`define FUP_RST_SECT 8'h00
`define FUP_RST_PAGE 8'h00
`endif

// *** design/fup_pkg.sv ***
// Types of the flash unlock and protect block
package fup_pkg;
    typedef enum logic [2:0] {
        FUP_LOCKED,
        FUP_KEY1_SEEN,
        FUP_KEY2_SEEN,
        FUP_UNLOCKED,
        FUP_PROGRAMMING
    } fup_state_t;
endpackage

// *** dv/fup_cpu_model.sv ***
// Wishbone master model of the CPU that drives the flash unlock and protect block
`timescale 1ns/10ps
`default_nettype none
`include "fup_params.svh"

module fup_cpu_model (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [3:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    initial
    begin
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    end

    // Single classic cycle, held until ack
    task automatic xfer(input logic we, input logic [3:0] adr, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= we;
        adr_o <= adr;
        sel_o <= 4'h1;
        dat_o <= {24'h000000, d};
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        dat_o <= ~dat_o;
    endtask

    // Page, both keys back to back, page again
    task automatic unlock(input logic [7:0] p1, input logic [7:0] p2);
        logic [31:0] q;
        xfer(1'b1, `FUP_ADR_PAGE, p1, q);
        xfer(1'b1, `FUP_ADR_CTRL, `FUP_KEY1, q);
        xfer(1'b1, `FUP_ADR_CTRL, `FUP_KEY2, q);
        xfer(1'b1, `FUP_ADR_PAGE, p2, q);
    endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking testbench of the flash unlock and protect block
`timescale 1ns/10ps
`default_nettype none
`include "fup_params.svh"

module tb_top;
    logic clk_i = 1'b0, rst_i = 1'b1, prog_req_i = 1'b0, dbg_mass_req_i = 1'b0;
    logic [15:0] prog_addr_i = 16'h0000;
    logic [7:0] prog_data_i = 8'h00;
    logic cyc, stb, we, ack, prog_ok, prog_stb, er_stb, mass_stb;
    logic [3:0] adr, sel;
    logic [31:0] dw, dr, q;
    logic [15:0] paddr, last_a, pa;
    logic [7:0] pdata, epage, last_d, last_p, pg, d;
    int fails = 0, cmp_count = 0, n_prog = 0, n_er = 0, n_mass = 0, n_ok = 0;

    initial
    begin
        forever #2 clk_i = ~clk_i;
    end

    fup_cpu_model fup_cpu_model_i (.clk_i(clk_i), .ack_i(ack), .dat_i(dr), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dw));
    fup_flash_unlock_and_protect fup_flash_unlock_and_protect_i (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
        .wb_dat_o(dr), .wb_ack_o(ack), .prog_req_i(prog_req_i), .prog_addr_i(prog_addr_i),
        .prog_data_i(prog_data_i), .prog_ok_o(prog_ok), .prog_strobe_o(prog_stb), .prog_addr_o(paddr),
        .prog_data_o(pdata), .erase_strobe_o(er_stb), .erase_page_o(epage),
        .dbg_mass_req_i(dbg_mass_req_i), .mass_strobe_o(mass_stb));

    // Strobe monitor
    always_ff @(posedge clk_i)
    begin
        if (prog_stb === 1'b1)
        begin
            n_prog <= n_prog + 1;
            last_a <= paddr;
            last_d <= pdata;
        end
        if (er_stb === 1'b1)
        begin
            n_er <= n_er + 1;
            last_p <= epage;
        end
        if (mass_stb === 1'b1)
            n_mass <= n_mass + 1;
        if (prog_ok === 1'b1)
            n_ok <= n_ok + 1;
    end

    function automatic logic [31:0] stat(input logic [2:0] st, input logic [7:0] cnt, input logic [7:0] p);
        return {8'h00, p, cnt, 5'h00, st};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        fup_cpu_model_i.xfer(1'b1, a, v, q);
    endtask

    task automatic rd(input logic [3:0] a);
        fup_cpu_model_i.xfer(1'b0, a, 8'h00, q);
    endtask

    task automatic prog(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk_i);
        prog_req_i <= 1'b1;
        prog_addr_i <= a;
        prog_data_i <= v;
        @(posedge clk_i);
        prog_req_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #100000;
        fails++;
        give_verdict();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'hd3e8));
        do_reset();
        pg = 8'($urandom % 128);
        rd(`FUP_ADR_STAT);
        chk("reset status", 32'h0, q);
        prog({pg[6:0], 9'h000}, 8'h5a);
        chk("locked prog", 0, n_prog);
        wr(`FUP_ADR_OPT, 8'h03);
        rd(`FUP_ADR_OPT);
        chk("options", 32'h3, q);
        fup_cpu_model_i.unlock(pg, pg);
        rd(`FUP_ADR_STAT);
        chk("unlocked status", stat(3'h3, 8'h00, pg), q & 32'h00ff0007);
        for (int i = 1; i <= 4; i++)
        begin
            d = 8'($urandom);
            pa = {pg[6:0], 9'($urandom)};
            prog(pa, d);
            chk("prog count", i, n_prog);
            chk("prog addr", {16'h0000, pa}, {16'h0000, last_a});
            chk("prog data", {24'h0, d}, {24'h0, last_d});
        end
        wr(`FUP_ADR_CTRL, 8'h11);
        rd(`FUP_ADR_STAT);
        chk("relock", 32'h0, q & 32'h7);
        prog({pg[6:0], 9'h001}, 8'h33);
        chk("prog after relock", 4, n_prog);
        $display("test unlock and program done");
        fup_cpu_model_i.unlock(pg, pg ^ 8'h01);
        rd(`FUP_ADR_STAT);
        chk("page mismatch", 32'h0, q & 32'h7);
        fup_cpu_model_i.unlock(pg, pg);
        wr(`FUP_ADR_CTRL, `FUP_CMD_ERASE);
        repeat (2) @(posedge clk_i);
        chk("erase count", 1, n_er);
        chk("erase page", {24'h0, pg}, {24'h0, last_p});
        $display("test erase done");
        wr(`FUP_ADR_CTRL, `FUP_CMD_SECSEL);
        wr(`FUP_ADR_PAGE, 8'hff);
        wr(`FUP_ADR_PAGE, 8'h00);
        rd(`FUP_ADR_PAGE);
        chk("sector protect", 32'hff, q);
        wr(`FUP_ADR_CTRL, 8'h11);
        fup_cpu_model_i.unlock(pg, pg);
        prog({pg[6:0], 9'h002}, 8'h44);
        wr(`FUP_ADR_CTRL, `FUP_CMD_ERASE);
        repeat (2) @(posedge clk_i);
        chk("protected erase", 1, n_er);
        chk("protected prog", 4, n_prog);
        wr(`FUP_ADR_CTRL, `FUP_CMD_MASS);
        rd(`FUP_ADR_STAT);
        chk("mass refused", 32'h100, q & 32'hff00);
        dbg_mass_req_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        dbg_mass_req_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("mass protected", 0, n_mass);
        $display("test protection done");
        do_reset();
        wr(`FUP_ADR_CTRL, `FUP_CMD_SECSEL);
        rd(`FUP_ADR_PAGE);
        chk("protect cleared", 32'h0, q);
        wr(`FUP_ADR_CTRL, 8'h11);
        fup_cpu_model_i.unlock(pg, pg);
        prog({pg[6:0], 9'h003}, 8'h55);
        wr(`FUP_ADR_CTRL, `FUP_CMD_ERASE);
        repeat (2) @(posedge clk_i);
        chk("options zero prog", 4, n_prog);
        chk("options zero erase", 1, n_er);
        dbg_mass_req_i <= 1'b1;
        @(posedge clk_i);
        dbg_mass_req_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("debug mass", 1, n_mass);
        chk("prog accept", 4, n_ok);
        $display("test reset and options done");
        give_verdict();
    end
endmodule
`default_nettype wire
